// *** inc/sar_adc_pkg.sv ***
package sar_adc_pkg;
	localparam int RESULT_WIDTH = 16;
	localparam int BYTE_WIDTH = 8;
	localparam int CLK_PERIOD_PS = 10000;
	localparam int CONVERSION_TIME_NS = 4700;
	// longest time, so round down
	localparam int CONVERSION_CYCLES = (CONVERSION_TIME_NS * 1000) / CLK_PERIOD_PS;
	localparam int SAR_CYCLES_PER_BIT = CONVERSION_CYCLES / RESULT_WIDTH;
	localparam int OUTPUT_DELAY_CYCLES = 2;
	localparam logic [RESULT_WIDTH-1:0] OFFSET_CODE = 16'h8000;
	localparam logic [RESULT_WIDTH-1:0] RESULT_RESET = 16'h0000;

	typedef enum {
		Shutdown,
		Armed,
		Acquire,
		Convert,
		Done,
		Drive
	} phase_t;

	typedef struct packed {
		logic convStrobeN;
		logic readSel;
		logic upperByteSel;
	} host_pins_t;

	typedef struct packed {
		logic [BYTE_WIDTH-1:0] resultBus;
		logic [BYTE_WIDTH-1:0] resultBusOe;
		logic convDoneN;
	} dev_pins_t;
endpackage

// *** design/pin_sync.sv ***
`timescale 1ns/1ps
module pin_sync #(
	parameter int WIDTH = 3
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [WIDTH-1:0] pinIn,
	output logic [WIDTH-1:0] pinOut
);
	////////////////////////////////////////////////////////////////
	typedef struct packed {
		logic [WIDTH-1:0] stage1;
		logic [WIDTH-1:0] stage2;
	} sync_t;

	sync_t state_reg;
	sync_t state_next;

	if (WIDTH < 1)
	begin : badWidth
		$error("pin_sync width must be at least one");
	end

	always_comb
	begin
		state_next.stage1 = pinIn;
		state_next.stage2 = state_reg.stage1;
	end

	// released high: strobe and selects are idle-high safe
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			state_reg <= '1;
		else
			state_reg <= state_next;
	end

	assign pinOut = state_reg.stage2;
endmodule // pin_sync

// *** design/sar_adc_parallel_readout.sv ***
`timescale 1ns/1ps
module sar_adc_parallel_readout #(
	parameter int CONV_CYCLES = sar_adc_pkg::CONVERSION_CYCLES,
	parameter int DELAY_CYCLES = sar_adc_pkg::OUTPUT_DELAY_CYCLES
) (
	input wire logic clk,
	input wire logic rst,
	input wire sar_adc_pkg::host_pins_t hostPins,
	input wire logic [sar_adc_pkg::RESULT_WIDTH-1:0] sampleValue,
	output sar_adc_pkg::dev_pins_t devPins,
	output logic poweredUp,
	output logic sampling
);
	////////////////////////////////////////////////////////////////
	localparam int CW = $clog2(CONV_CYCLES + 1);
	localparam int DW = $clog2(DELAY_CYCLES + 1);

	typedef struct packed {
		sar_adc_pkg::phase_t phase;
		logic strobePrev;
		logic shutAfter;
		logic [CW-1:0] convCount;
		logic [DW-1:0] delayCount;
		logic [sar_adc_pkg::RESULT_WIDTH-1:0] sample;
		logic [sar_adc_pkg::RESULT_WIDTH-1:0] result;
		logic doneN;
		logic [sar_adc_pkg::BYTE_WIDTH-1:0] busData;
		logic busOe;
	} state_t;

	state_t state_reg;
	state_t state_next;
	sar_adc_pkg::host_pins_t pins;
	logic strobeFall;

	// a longer count would break the conversion time limit
	if (CONV_CYCLES < 1 || CONV_CYCLES > sar_adc_pkg::CONVERSION_CYCLES)
	begin : badConvCount
		$error("conversion count must be 1..maximum conversion time");
	end
	if (DELAY_CYCLES < 1)
	begin : badDelay
		$error("output delay must be at least one cycle");
	end

	////////////////////////////////////////////////////////////////
	pin_sync #(
		.WIDTH(3)
	) syncPins (
		.clk(clk),
		.rst(rst),
		.pinIn(hostPins),
		.pinOut(pins)
	);

	assign strobeFall = state_reg.strobePrev && !pins.convStrobeN;

	function automatic logic [sar_adc_pkg::BYTE_WIDTH-1:0] pickByte(
		input logic [sar_adc_pkg::RESULT_WIDTH-1:0] word,
		input logic upper
	);
		pickByte = upper ? word[15:8] : word[7:0];
	endfunction

	////////////////////////////////////////////////////////////////
	always_comb
	begin
		state_next = state_reg;
		state_next.strobePrev = pins.convStrobeN;
		unique case (state_reg.phase)
			sar_adc_pkg::Shutdown, sar_adc_pkg::Armed:
			begin
				if (strobeFall && !pins.readSel)
				begin
					state_next.phase = sar_adc_pkg::Acquire;
					state_next.doneN = 1'b1;
				end
			end
			sar_adc_pkg::Acquire:
			begin
				if (strobeFall)
				begin
					// sample frozen at the hold instant
					state_next.phase = sar_adc_pkg::Convert;
					state_next.sample = sampleValue;
					state_next.shutAfter = pins.readSel;
					state_next.convCount = CW'(CONV_CYCLES - 1);
				end
			end
			sar_adc_pkg::Convert:
			begin
				if (state_reg.convCount == '0)
				begin
					state_next.phase = sar_adc_pkg::Done;
					// input taken as two's complement, flip msb
					state_next.result = state_reg.sample ^ sar_adc_pkg::OFFSET_CODE;
					state_next.doneN = 1'b0;
				end
				else
					state_next.convCount = state_reg.convCount - 1'b1;
			end
			sar_adc_pkg::Done:
			begin
				if (strobeFall && pins.readSel)
				begin
					state_next.phase = sar_adc_pkg::Drive;
					state_next.delayCount = DW'(DELAY_CYCLES - 1);
				end
				else if (strobeFall)
				begin
					// a fall with read low skips the readout and restarts
					state_next.phase = sar_adc_pkg::Acquire;
					state_next.doneN = 1'b1;
				end
			end
			sar_adc_pkg::Drive:
			begin
				if (pins.convStrobeN)
				begin
					state_next.busOe = 1'b0;
					state_next.phase = state_reg.shutAfter ?
						sar_adc_pkg::Shutdown : sar_adc_pkg::Armed;
				end
				else if (state_reg.delayCount != '0)
					state_next.delayCount = state_reg.delayCount - 1'b1;
				else
				begin
					state_next.busOe = 1'b1;
					state_next.busData = pickByte(state_reg.result, pins.upperByteSel);
				end
			end
		endcase
		if (state_next.phase != sar_adc_pkg::Drive)
			state_next.busOe = 1'b0;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_reg.phase <= sar_adc_pkg::Shutdown;
			state_reg.strobePrev <= 1'b1;
			state_reg.shutAfter <= 1'b1;
			state_reg.convCount <= '0;
			state_reg.delayCount <= '0;
			state_reg.sample <= sar_adc_pkg::RESULT_RESET;
			state_reg.result <= sar_adc_pkg::RESULT_RESET;
			state_reg.doneN <= 1'b1;
			state_reg.busData <= '0;
			state_reg.busOe <= 1'b0;
		end
		else
			state_reg <= state_next;
	end

	////////////////////////////////////////////////////////////////
	assign devPins.resultBus = state_reg.busData;
	assign devPins.resultBusOe = {sar_adc_pkg::BYTE_WIDTH{state_reg.busOe}};
	assign devPins.convDoneN = state_reg.doneN;
	// shutdown is the only phase with reference off
	assign poweredUp = state_reg.phase != sar_adc_pkg::Shutdown;
	assign sampling = state_reg.phase == sar_adc_pkg::Acquire;
endmodule // sar_adc_parallel_readout

// *** tb/sar_adc_asserts.sv ***
`timescale 1ns/1ps
module sar_adc_asserts #(
	parameter int CONV_CYCLES = 8,
	parameter int DELAY_CYCLES = 2
) (
	input wire logic clk,
	input wire logic rst,
	input wire sar_adc_pkg::host_pins_t hostPins,
	input wire sar_adc_pkg::dev_pins_t devPins,
	input wire logic sampling
);
	localparam int LIM = CONV_CYCLES + 6;
	localparam int RD = DELAY_CYCLES + 6;
	// set once a readout has ended; a later fall with read high is ignored
	logic oePrev;
	logic readOver;
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			oePrev <= 1'b0;
			readOver <= 1'b0;
		end
		else
		begin
			oePrev <= devPins.resultBusOe[0];
			if (devPins.convDoneN)
				readOver <= 1'b0;
			else if (oePrev && !devPins.resultBusOe[0])
				readOver <= 1'b1;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	oe_uniform_a: assert property (devPins.resultBusOe inside {8'h00, 8'hff})
		else $error("enables differ");
	acq_quiet_a: assert property (sampling |-> devPins.resultBusOe == 8'h00)
		else $error("bus driven");
	flag_high_a: assert property (sampling [*2] |-> devPins.convDoneN)
		else $error("flag low");
	read_valid_a: assert property ($rose(devPins.resultBusOe[0]) |-> !devPins.convDoneN)
		else $error("early drive");
	read_start_a: assert property ($fell(hostPins.convStrobeN) && hostPins.readSel
		&& !devPins.convDoneN && !readOver |-> ##[3:RD] devPins.resultBusOe[0])
		else $error("no drive");
	bus_release_a: assert property (hostPins.convStrobeN [*6] |-> !devPins.resultBusOe[0])
		else $error("bus held");
	conv_time_a: assert property ($fell(sampling) |-> ##[1:LIM] !devPins.convDoneN)
		else $error("slow");
	acq_start_a: assert property ($rose(sampling) |-> !$past(hostPins.convStrobeN, 2)
		&& !$past(hostPins.readSel, 2)) else $error("bad acquire");
endmodule // sar_adc_asserts

bind sar_adc_parallel_readout sar_adc_asserts #(.CONV_CYCLES(CONV_CYCLES),
	.DELAY_CYCLES(DELAY_CYCLES)) chk (.clk(clk), .rst(rst), .hostPins(hostPins),
	.devPins(devPins), .sampling(sampling));

// *** tb/host_model.sv ***
`timescale 1ns/1ps
module host_model #(
	// stand-in for the reference wake time, cut short to keep runs brief
	parameter int SETTLE_CYCLES = 50
) (
	input wire logic clk,
	output sar_adc_pkg::host_pins_t pins
);
	initial pins = 3'b100;
	// select settles a cycle ahead of the strobe fall
	task automatic fall(input logic rs);
		@(negedge clk) pins.readSel = rs;
		@(negedge clk) pins.convStrobeN = 1'b0;
		repeat (6) @(negedge clk);
	endtask
	task automatic rise();
		@(negedge clk) pins.convStrobeN = 1'b1;
		repeat (8) @(negedge clk);
	endtask
	task automatic settle();
		repeat (SETTLE_CYCLES) @(negedge clk);
	endtask
	task automatic pick(input logic hb);
		@(negedge clk) pins.upperByteSel = hb;
		repeat (4) @(negedge clk);
	endtask
endmodule // host_model

// *** tb/sar_adc_parallel_readout_bench.sv ***
`timescale 1ns/1ps
module sar_adc_parallel_readout_bench;
	logic clk;
	logic rst;
	logic [15:0] sampleValue;
	sar_adc_pkg::host_pins_t hostPins;
	sar_adc_pkg::dev_pins_t devPins;
	logic poweredUp;
	logic sampling;
	int mismatches = 0;
	int nTests = 0;
	int cycles = 0;
	host_model host (.clk(clk), .pins(hostPins));
	sar_adc_parallel_readout DUT (.clk(clk), .rst(rst),
		.hostPins(hostPins), .sampleValue(sampleValue), .devPins(devPins),
		.poweredUp(poweredUp), .sampling(sampling));
	task automatic check(input logic ok, input string msg);
		nTests++;
		if (ok !== 1'b1)
		begin
			mismatches++;
			$display("MISMATCH %0t %s", $time, msg);
		end
	endtask
	task automatic summarize();
		$display("mismatches %0d checks %0d", mismatches, nTests);
		if (mismatches == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic ignoreFall(input logic up, input logic doneN);
		host.fall(1'b1);
		check(sampling === 1'b0 && poweredUp === up, "fall not ignored");
		check(devPins.convDoneN === doneN && devPins.resultBusOe === 8'h00, "reread");
		host.rise();
	endtask
	// converts and leaves the result unread, so the next fall takes the skip path
	task automatic skipRead();
		host.fall(1'b0);
		host.rise();
		host.fall(1'b0);
		repeat (sar_adc_pkg::CONVERSION_CYCLES) @(negedge clk);
		check(devPins.convDoneN === 1'b0 && devPins.resultBusOe === 8'h00, "unread");
		host.rise();
	endtask
	task automatic runCycle(input logic [15:0] val, input logic shut);
		logic [15:0] exp;
		logic wasDown;
		exp = val ^ 16'h8000;
		wasDown = !poweredUp;
		sampleValue = val;
		host.fall(1'b0);
		check(sampling === 1'b1 && devPins.convDoneN === 1'b1, "acq");
		host.rise();
		if (wasDown)
			host.settle();
		host.fall(shut);
		// channel switched just after the hold; the held sample must survive
		sampleValue = ~val;
		check(devPins.resultBusOe === 8'h00 && sampling === 1'b0, "conv");
		// fall returns 3.5 cycles after the hold edge: no slack beyond the limit
		repeat (sar_adc_pkg::CONVERSION_CYCLES - 3)
			if (devPins.convDoneN === 1'b1) @(negedge clk);
		check(devPins.convDoneN === 1'b0, "no done");
		host.rise();
		host.fall(1'b1);
		host.pick(1'b0);
		check(devPins.resultBusOe === 8'hff && devPins.resultBus === exp[7:0], "lo");
		host.pick(1'b1);
		check(devPins.resultBus === exp[15:8], "hi");
		host.rise();
		check(devPins.resultBusOe === 8'h00 && sampling === 1'b0, "idle");
		check(poweredUp === !shut, "power");
	endtask
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// hang guard, about twice the roughly 2800 cycles used
	always @(posedge clk)
	begin
		cycles++;
		if (cycles == 6000)
		begin
			mismatches++;
			summarize();
		end
	end
	initial
	begin
		rst = 1'b1;
		sampleValue = 16'h0000;
		repeat (6) @(negedge clk);
		rst = 1'b0;
		@(negedge clk);
		check(devPins.resultBusOe === 8'h00 && devPins.convDoneN === 1'b1, "reset");
		ignoreFall(1'b0, 1'b1);
		runCycle(16'h0000, 1'b0);
		ignoreFall(1'b1, 1'b0);
		runCycle(16'h7fff, 1'b1);
		ignoreFall(1'b0, 1'b0);
		runCycle(16'h8000, 1'b0);
		skipRead();
		runCycle(16'h1234, 1'b0);
		summarize();
	end
endmodule // sar_adc_parallel_readout_bench
